// ===== bscan_pkg.sv
// Package for the boundary-scan test port: TAP states, instruction codes,
// boundary chain layout and the pin groups that the chain surrounds.
// Assumes a 169-cell chain and a two-bit instruction register.
package bscan_pkg;

    localparam int BSR_LEN      = 169;   // Cells 0 to 168
    localparam int IR_W         = 2;
    localparam int MISC_PINS    = 24;    // Input-only cells 0 to 23
    localparam int DBUS_W       = 16;
    localparam int STREAMS      = 32;
    localparam int STREAM_GRP   = 8;
    localparam int ACK_CELL     = 24;    // Transfer-acknowledge output cell
    localparam int DBUS_BASE    = 25;    // D15 control cell
    localparam int TX_GRP0_BASE = 145;   // TX7 control cell
    localparam int RX_GRP0_BASE = 161;   // RX7 input cell
    localparam int GRP_STRIDE   = 24;

    localparam logic [IR_W-1:0] IR_EXTEST  = 2'h0;
    localparam logic [IR_W-1:0] IR_BYPASS  = 2'h3;
    localparam logic [IR_W-1:0] IR_RESET   = 2'h3;  // Non-invasive after reset
    localparam logic [IR_W-1:0] IR_CAPTURE = 2'h1;  // Fixed capture pattern

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;

    // Values that drive the device's output pins
    typedef struct packed {
        logic                  xfer_ack;
        logic [DBUS_W-1:0]     d_out;
        logic [DBUS_W-1:0]     d_oe;
        logic [STREAMS-1:0]    tx;
        logic [STREAMS-1:0]    tx_oe;
    } pin_drive_t;

    // Levels seen on the device's input pins
    typedef struct packed {
        logic [MISC_PINS-1:0]  misc;
        logic [DBUS_W-1:0]     d_in;
        logic [STREAMS-1:0]    rx;
    } pin_sense_t;

    // Data bit b: control, output, input cells, bit 15 first
    function automatic int dbus_ctl_pos(input int b);
        return DBUS_BASE + 3 * (DBUS_W - 1 - b);
    endfunction

    // Transmit stream s: control cell, output cell follows
    function automatic int tx_ctl_pos(input int s);
        return TX_GRP0_BASE - GRP_STRIDE * (s / STREAM_GRP)
               + 2 * (STREAM_GRP - 1 - s % STREAM_GRP);
    endfunction

    // Receive stream s: input cell
    function automatic int rx_pos(input int s);
        return RX_GRP0_BASE - GRP_STRIDE * (s / STREAM_GRP)
               + (STREAM_GRP - 1 - s % STREAM_GRP);
    endfunction

endpackage

// ===== bscan_test_port.sv
// Boundary-scan test port: TAP controller, instruction register, bypass
// cell and 169-cell boundary chain, plus the pin muxes for external test.
// Assumes the core runs on clk and the test controller drives tck freely.
`timescale 1ns/1ps

// Summary of operation
// - Test logic clocked by tck, core undisturbed
// - TMS sampled on rising tck
// - TMS and TDI pulled high when undriven
// - TDI captured rising tck into IR/DR
// - TDO shifts out on falling tck
// - TDO high impedance outside shift states
// - Test reset clears scan logic, pulled high
// - Two-bit IR shifts in Shift-IR, loads on Update-IR
// - Instruction selects active data register path
// - 00 EXTEST, 11 BYPASS, else SAMPLE/PRELOAD
// - Only boundary and bypass data registers
// - Bypass is one-stage TDI-to-TDO path
// - Cells 0 to 168, cell 0 out first
// - Control cell one enables its driver
// - Inputs 0-23, ack 24, data triples 25-72
// - Four stream groups from 73: pairs 73-88, receive cells 89-96
// - Standard TAP state machine sequencing
module bscan_test_port
    import bscan_pkg::*;
(
    input  wire logic                  clk,         // Core clock, 40 MHz
    input  wire logic                  resetn,      // Core reset, sync, low
    input  wire logic                  tck,         // Test clock
    input  wire logic                  tms,         // Mode select level
    input  wire logic                  tms_en,      // Controller drives tms
    input  wire logic                  tdi,         // Test data in level
    input  wire logic                  tdi_en,      // Controller drives tdi
    input  wire logic                  trst_n,      // Test reset level, low
    input  wire logic                  trst_en,     // Controller drives trst
    output logic                       tdo,         // Test data out
    output logic                       tdo_oe,      // Test data out driven
    input  wire bscan_pkg::pin_drive_t core_drive,  // Core's pin outputs
    input  wire bscan_pkg::pin_sense_t pin_sense,   // Input pin levels
    output bscan_pkg::pin_drive_t      pin_drive    // To the output pads
);
    import bscan_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pull-ups on undriven test inputs
    // Each enable input says whether the controller drives the pin; a
    // floating pin reads high, so a missing controller leaves the TAP
    // parked in Test-Logic-Reset and the reset pin released.

    wire tms_eff   = tms_en  ? tms    : 1'b1;
    wire tdi_eff   = tdi_en  ? tdi    : 1'b1;
    wire trst_eff  = trst_en ? trst_n : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // TAP controller, tck domain
    // Test reset is asynchronous so the port goes quiet even with tck
    // stopped; release is expected while tck idles low.

    tap_state_t state;
    tap_state_t next_state;

    // Standard sixteen-state walk on TMS
    // Five tck cycles with tms high reach Test-Logic-Reset from anywhere
    always_comb begin
        case (state)
            TLR:     next_state = tms_eff ? TLR    : RTI;
            RTI:     next_state = tms_eff ? SEL_DR : RTI;
            SEL_DR:  next_state = tms_eff ? SEL_IR : CAP_DR;
            CAP_DR:  next_state = tms_eff ? EX1_DR : SH_DR;
            SH_DR:   next_state = tms_eff ? EX1_DR : SH_DR;
            EX1_DR:  next_state = tms_eff ? UPD_DR : PA_DR;
            PA_DR:   next_state = tms_eff ? EX2_DR : PA_DR;
            EX2_DR:  next_state = tms_eff ? UPD_DR : SH_DR;
            UPD_DR:  next_state = tms_eff ? SEL_DR : RTI;
            SEL_IR:  next_state = tms_eff ? TLR    : CAP_IR;
            CAP_IR:  next_state = tms_eff ? EX1_IR : SH_IR;
            SH_IR:   next_state = tms_eff ? EX1_IR : SH_IR;
            EX1_IR:  next_state = tms_eff ? UPD_IR : PA_IR;
            PA_IR:   next_state = tms_eff ? EX2_IR : PA_IR;
            EX2_IR:  next_state = tms_eff ? UPD_IR : SH_IR;
            UPD_IR:  next_state = tms_eff ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    // TMS sampled on the rising test clock only
    always_ff @(posedge tck or negedge trst_eff) begin
        if (!trst_eff) begin
            state <= TLR;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction register and decode
    // Shift stage and current instruction are separate, so an instruction
    // scan leaves the active data path untouched until Update-IR.
    // Capture-IR loads a fixed pattern so the controller can check the path.

    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] ir;

    wire sel_extest = (ir == IR_EXTEST);
    wire sel_bypass = (ir == IR_BYPASS);
    wire sel_bsr    = !sel_bypass;
    wire shifting   = (state == SH_DR) || (state == SH_IR);

    // Shift path only in Shift-IR; latched on Update-IR
    // Test-Logic-Reset forces the non-invasive instruction back in
    always_ff @(posedge tck or negedge trst_eff) begin
        if (!trst_eff) begin
            ir_shift <= IR_RESET;
            ir       <= IR_RESET;
        end else begin
            if (state == CAP_IR) begin
                ir_shift <= IR_CAPTURE;
            end else if (state == SH_IR) begin
                ir_shift <= {tdi_eff, ir_shift[IR_W-1:1]};
            end
            if (state == TLR) begin
                ir <= IR_RESET;
            end else if (state == UPD_IR) begin
                ir <= ir_shift;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture vector: core values and pin levels mapped onto the chain
    // Captured values are two tck cycles old; faster changes go unseen,
    // a limitation accepted to keep every pin and core output behind a
    // proper synchroniser.

    pin_sense_t sense_meta;
    pin_sense_t sense_sync;
    pin_drive_t core_meta;
    pin_drive_t core_sync;
    logic [BSR_LEN-1:0] cap;

    // Pins and core outputs belong to other clocks; two flops first
    // Cleared on test reset so capture never shows unknowns
    always_ff @(posedge tck or negedge trst_eff) begin
        if (!trst_eff) begin
            sense_meta <= '0;
            sense_sync <= '0;
            core_meta  <= '0;
            core_sync  <= '0;
        end else begin
            sense_meta <= pin_sense;
            sense_sync <= sense_meta;
            core_meta  <= core_drive;
            core_sync  <= core_meta;
        end
    end

    // Acknowledge output value from the core
    assign cap[ACK_CELL] = core_sync.xfer_ack;

    genvar gi;
    generate
        for (gi = 0; gi < MISC_PINS; gi++) begin : g_misc
            assign cap[gi] = sense_sync.misc[gi];
        end
        for (gi = 0; gi < DBUS_W; gi++) begin : g_dbus
            assign cap[dbus_ctl_pos(gi)]     = core_sync.d_oe[gi];
            assign cap[dbus_ctl_pos(gi) + 1] = core_sync.d_out[gi];
            assign cap[dbus_ctl_pos(gi) + 2] = sense_sync.d_in[gi];
        end
        for (gi = 0; gi < STREAMS; gi++) begin : g_stream
            assign cap[tx_ctl_pos(gi)]     = core_sync.tx_oe[gi];
            assign cap[tx_ctl_pos(gi) + 1] = core_sync.tx[gi];
            assign cap[rx_pos(gi)]         = sense_sync.rx[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Data registers: boundary chain, update latch, bypass cell
    // The update latch changes only on Update-DR, so the pads see no
    // ripple while the chain shifts. The toggle tells the core side
    // that a new update word stands still and may be copied.

    logic [BSR_LEN-1:0] bsr;
    logic [BSR_LEN-1:0] bsr_upd;
    logic               bypass_cell;
    logic               upd_toggle;

    // Cell 168 nearest TDI, cell 0 leaves first
    // Bypass captures zero so a chain of devices can be counted
    always_ff @(posedge tck or negedge trst_eff) begin
        if (!trst_eff) begin
            bsr         <= '0;
            bsr_upd     <= '0;
            bypass_cell <= 1'b0;
            upd_toggle  <= 1'b0;
        end else begin
            if (state == CAP_DR && sel_bsr) begin
                bsr <= cap;
            end else if (state == SH_DR && sel_bsr) begin
                bsr <= {tdi_eff, bsr[BSR_LEN-1:1]};
            end
            if (state == UPD_DR && sel_bsr) begin
                bsr_upd <= bsr;
            end
            if (state == CAP_DR && sel_bypass) begin
                bypass_cell <= 1'b0;
            end else if (state == SH_DR && sel_bypass) begin
                bypass_cell <= tdi_eff;
            end
            if (state == UPD_DR || state == UPD_IR) begin
                upd_toggle <= !upd_toggle;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // TDO on the falling test clock
    // Enable follows the shift states only; the pad is released in every
    // other state so several devices may share the test bus.

    wire next_tdo = (state == SH_IR) ? ir_shift[0] :
                    sel_bypass       ? bypass_cell : bsr[0];

    // Falling edge gives the controller a half period of setup
    always_ff @(negedge tck or negedge trst_eff) begin
        if (!trst_eff) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= next_tdo;
            tdo_oe <= shifting;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing into clk: EXTEST level and update word by toggle
    // The update word is copied whole only after the synchronised toggle
    // moves; it is never sampled bit by bit, so no mixed word reaches the
    // pads. Updates closer than about three clk cycles would be missed,
    // so tck is assumed to run well below clk, as in normal test use.

    logic               ext_meta;
    logic               ext_sync;
    logic               tog_meta;
    logic               tog_sync;
    logic               tog_prev;
    logic [BSR_LEN-1:0] upd_held;
    pin_drive_t         ext_drive;

    wire tog_event = tog_sync ^ tog_prev;

    // Update word is stable for several tck cycles after each toggle
    // The EXTEST level rides through its own two flops
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_prev <= 1'b0;
            upd_held <= '0;
        end else begin
            ext_meta <= sel_extest;
            ext_sync <= ext_meta;
            tog_meta <= upd_toggle;
            tog_sync <= tog_meta;
            tog_prev <= tog_sync;
            if (tog_event) begin
                upd_held <= bsr_upd;
            end
        end
    end

    // Update cells laid back into pin order
    // Acknowledge output has no control cell and is always driven
    assign ext_drive.xfer_ack = upd_held[ACK_CELL];
    generate
        for (gi = 0; gi < DBUS_W; gi++) begin : g_ext_dbus
            assign ext_drive.d_oe[gi]  = upd_held[dbus_ctl_pos(gi)];
            assign ext_drive.d_out[gi] = upd_held[dbus_ctl_pos(gi) + 1];
        end
        for (gi = 0; gi < STREAMS; gi++) begin : g_ext_tx
            assign ext_drive.tx_oe[gi] = upd_held[tx_ctl_pos(gi)];
            assign ext_drive.tx[gi]    = upd_held[tx_ctl_pos(gi) + 1];
        end
    endgenerate

    wire pin_drive_t next_pin_drive = ext_sync ? ext_drive : core_drive;

    // Pads follow the core unless EXTEST is current
    // Registered so the switch between core and test values is glitch
    // free; pads lag the core by one clk cycle in normal operation.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_drive <= '0;
        end else begin
            pin_drive <= next_pin_drive;
        end
    end

endmodule

// ===== bscan_test_port_sva.sv
// Concurrent checks on the boundary-scan test port, seen at its ports.
// Assumes a bind onto bscan_test_port; tck stands still between scans.
`timescale 1ns/1ps
module bscan_test_port_sva
    import bscan_pkg::*;
(
    input wire logic                  clk,        // Core clock
    input wire logic                  resetn,     // Core reset, low
    input wire logic                  tck,        // Test clock
    input wire logic                  tms,        // Mode select
    input wire logic                  tms_en,     // Mode select driven
    input wire logic                  trst_n,     // Test reset, low
    input wire logic                  trst_en,    // Test reset driven
    input wire logic                  tdo,        // Test data out
    input wire logic                  tdo_oe,     // Test data out driven
    input wire bscan_pkg::pin_drive_t core_drive, // Core pin outputs
    input wire bscan_pkg::pin_drive_t pin_drive   // Pad drive
);
    ////////////////////////////////////////////////////////////
    // Pull-ups folded in: an undriven pin reads high
    wire trst_on = trst_en && !trst_n;
    wire tms_hi  = !tms_en || tms;

    // Reset and pad checks in the core domain
    chk_reset_quiet: assert property (@(posedge clk) trst_on |-> !tdo && !tdo_oe)
        else $error("tdo active during test reset");
    chk_tdo_fall_only: assert property (@(posedge clk) disable iff (!resetn)
        tck && $past(tck) && !trst_on |-> $stable(tdo)) else $error("tdo moved with tck high");
    chk_oe_fall_only: assert property (@(posedge clk) disable iff (!resetn)
        tck && $past(tck) && !trst_on |-> $stable(tdo_oe)) else $error("oe moved, tck high");
    chk_pad_reset: assert property (@(posedge clk) !resetn |=> pin_drive == '0)
        else $error("pads not cleared by core reset");
    chk_pad_follow: assert property (@(posedge clk) disable iff (!resetn)
        trst_on [*6] |=> pin_drive == $past(core_drive)) else $error("pads not from core");

    // Shift window follows the TAP walk; tck domain
    chk_shift_entry: assert property (@(posedge tck) disable iff (trst_on)
        $rose(tdo_oe) |-> $past(!tms_hi)) else $error("shift entered with tms high");
    chk_shift_exit: assert property (@(posedge tck) disable iff (trst_on)
        $fell(tdo_oe) |-> $past(tms_hi)) else $error("shift left with tms low");
    chk_tlr_quiet: assert property (@(posedge tck) disable iff (trst_on)
        tms_hi [*5] |-> ##1 !tdo_oe) else $error("tdo driven after five tms high");

    // Main scenarios reached
    cov_shift: cover property (@(posedge tck) $rose(tdo_oe));
    cov_trst: cover property (@(posedge clk) trst_on);
    cov_extest: cover property (@(posedge clk) resetn && pin_drive != core_drive);
endmodule

// ===== tap_ctl_model.sv
// External test controller: drives the TAP pins and walks the states.
// Assumes tck is made only inside its tasks, so it idles low between scans.
`timescale 1ns/1ps
module tap_ctl_model (
    output logic      tck,     // Test clock, runs only inside the tasks
    output logic      tms,     // Mode select
    output logic      tms_en,  // Mode select driven
    output logic      tdi,     // Test data in
    output logic      tdi_en,  // Test data driven
    output logic      trst_n,  // Test reset, low
    output logic      trst_en, // Test reset driven
    input  wire logic tdo      // Test data out
);
    initial begin
        {tck, tms, tdi, trst_n} = 4'h7;
        {tms_en, tdi_en, trst_en} = 3'h7;
    end

    // One tck period; levels set half a phase before the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #40 tck = 1'b1;
        q = tdo;
        #80 tck = 0;
        #40;
    endtask

    // Asynchronous reset, then settle in Run-Test/Idle
    task automatic trst_pulse;
        logic o;
        trst_n = 0;
        #200 trst_n = 1'b1;
        step(1'b0, 1'b0, o);
    endtask

    // Full scan from idle: IR when ir is set, else DR; back to idle
    task automatic shift(input bit ir, input int n, input logic [169:0] d,
                         output logic [169:0] q);
        logic o;
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // Leave reset pin floating low-valued: the pull-up must win
    task automatic float_trst;
        trst_en = 0;
        trst_n = 0;
        #600 trst_n = 1'b1;
        trst_en = 1'b1;
    endtask

    // Undriven tms and tdi with low values behind them for five clocks
    task automatic float_tms;
        logic o;
        tms_en = 0;
        tdi_en = 0;
        repeat (5) step(1'b0, 1'b0, o);
        {tms_en, tdi_en} = 2'h3;
    endtask
endmodule

// ===== testbench.sv
// Testbench for the boundary-scan test port with a controller model.
// Assumes bscan_pkg, the design and tap_ctl_model are compiled first.
`timescale 1ns/1ps
module testbench;
    import bscan_pkg::*;
    logic       clk, resetn, tck, tms, tms_en, tdi, tdi_en, trst_n, trst_en, tdo, tdo_oe;
    pin_drive_t core_drive, pin_drive;
    pin_sense_t pin_sense;
    int         fail_count, checks_done, cycles;
    logic [169:0] q;

    always #12.5 clk = ~clk;

    bscan_test_port u_dut (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms),
        .tms_en(tms_en), .tdi(tdi), .tdi_en(tdi_en), .trst_n(trst_n), .trst_en(trst_en),
        .tdo(tdo), .tdo_oe(tdo_oe), .core_drive(core_drive), .pin_sense(pin_sense),
        .pin_drive(pin_drive));
    // A released tdo shows the inverse of its last value to the model
    tap_ctl_model u_ctl (.tck(tck), .tms(tms), .tms_en(tms_en), .tdi(tdi),
        .tdi_en(tdi_en), .trst_n(trst_n), .trst_en(trst_en), .tdo(tdo_oe ? tdo : !tdo));

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // IR capture pattern, then the reset instruction's one-cell path
    task automatic t_ir_bypass;
        u_ctl.shift(1'b1, 2, 170'h3, q);
        check("ir capture", q[1:0], 2'h1);
        u_ctl.shift(1'b0, 4, 170'hB, q);
        check("bypass path", q[3:0], 4'h6);
        check("oe idle", tdo_oe, 1'b0);
    endtask

    // Both sample codes: captured pins land in their cells, chain is 169
    task automatic t_sample;
        for (int c = 1; c <= 2; c++) begin
            u_ctl.shift(1'b1, 2, 170'(c), q);
            u_ctl.shift(1'b0, 170, 170'h1, q);
            check("misc cells", q[23:0], pin_sense.misc);
            check("d15 input", q[27], pin_sense.d_in[15]);
            check("d0 input", q[72], pin_sense.d_in[0]);
            check("rx31 rx28", {q[89], q[92]}, {pin_sense.rx[31], pin_sense.rx[28]});
            check("rx0 last", q[168], pin_sense.rx[0]);
            check("chain end", q[169], 1'b1);
        end
    endtask

    // Preload, then external test drives the pads from the update cells
    task automatic t_extest;
        u_ctl.shift(1'b1, 2, 170'h1, q);
        u_ctl.shift(1'b0, 169, (170'h7 << 24) | (170'h3 << 73), q);
        u_ctl.shift(1'b1, 2, 170'h0, q);
        repeat (10) @(negedge clk);
        check("ack cell", pin_drive.xfer_ack, 1'b1);
        check("d15 oe out", {pin_drive.d_oe[15], pin_drive.d_out[15]}, 2'h3);
        check("d14 oe", pin_drive.d_oe[14], 1'b0);
        check("tx31 oe out", {pin_drive.tx_oe[31], pin_drive.tx[31]}, 2'h3);
        check("tx24 oe", pin_drive.tx_oe[24], 1'b0);
    endtask

    // Floating reset keeps test mode; floating tms walks to reset state
    task automatic t_pullup;
        u_ctl.float_trst();
        check("trst float", pin_drive.xfer_ack, 1'b1);
        u_ctl.float_tms();
        repeat (10) @(negedge clk);
        check("tms float", pin_drive, core_drive);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        clk = 0;
        resetn <= 0;
        core_drive <= {1'b0, 16'hC3A5, 16'hFFFF, 32'h1234ABCD, 32'hFFFF0000};
        pin_sense <= {24'hA53C96, 16'h8001, 32'h80000001};
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        u_ctl.trst_pulse();
        t_ir_bypass();
        t_sample();
        t_extest();
        t_pullup();
        tally_and_finish();
    end
endmodule

bind bscan_test_port bscan_test_port_sva u_sva (.clk(clk), .resetn(resetn), .tck(tck),
    .tms(tms), .tms_en(tms_en), .trst_n(trst_n), .trst_en(trst_en), .tdo(tdo),
    .tdo_oe(tdo_oe), .core_drive(core_drive), .pin_drive(pin_drive));
